// >>> include/tmb_pkg.sv
/*
  shared constants, types and helpers for the channel B compare/capture
  block and its register file.
  assumes: byte-wide register port with a 4-bit address; one 125 MHz clock.
*/
package tmb_pkg;

  // register offsets on the byte port
  localparam logic [3:0] OFS_CHAN_B_CONTROL = 4'h0;
  localparam logic [3:0] OFS_COUNTER_LOW = 4'h1;
  localparam logic [3:0] OFS_COUNTER_HIGH = 4'h2;
  localparam logic [3:0] OFS_COMPARE_A_LOW = 4'h3;
  localparam logic [3:0] OFS_COMPARE_A_HIGH = 4'h4;
  localparam logic [3:0] OFS_COMPARE_B_LOW = 4'h5;
  localparam logic [3:0] OFS_COMPARE_B_HIGH = 4'h6;
  localparam logic [3:0] OFS_TIMER_CTRL = 4'h7;

  // chan_b_control field positions
  localparam int POS_MODE_SEL = 6;
  localparam int POS_PIN_FUNCTION = 4;
  localparam int POS_OUTPUT_LEVEL = 3;
  localparam int POS_POLARITY = 2;
  localparam int POS_PWM_ALIGN = 0;

  // timer_ctrl field positions
  localparam int POS_TIMER_ON = 0;
  localparam int POS_PIN_DRIVE_EN = 1;
  localparam int POS_CAPTURE_FLAG = 2;
  localparam int POS_OUT_STATE = 3;
  localparam int POS_COUNT_DOWN = 4;

  // reset values
  localparam logic [7:0] RST_CHAN_B_CONTROL = 8'h00;
  localparam logic [9:0] RST_COUNTER = 10'h000;
  localparam logic [9:0] RST_COMPARE = 10'h000;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // counter limits
  localparam logic [9:0] CNT_TOP = 10'h3ff;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;

  // channel B operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } tmb_mode_t;

  // pin function codes, one set per mode other than timer
  localparam logic [1:0] CMP_FN_KEEP = 2'b00;
  localparam logic [1:0] CMP_FN_LOW = 2'b01;
  localparam logic [1:0] CMP_FN_HIGH = 2'b10;
  localparam logic [1:0] CMP_FN_TOGGLE = 2'b11;
  localparam logic [1:0] PWM_FN_INACTIVE = 2'b00;
  localparam logic [1:0] PWM_FN_ACTIVE = 2'b01;
  localparam logic [1:0] PWM_FN_WAVE = 2'b10;
  localparam logic [1:0] PWM_FN_PULSE = 2'b11;
  localparam logic [1:0] CAP_FN_RISE = 2'b00;
  localparam logic [1:0] CAP_FN_FALL = 2'b01;
  localparam logic [1:0] CAP_FN_BOTH = 2'b10;
  localparam logic [1:0] CAP_FN_OFF = 2'b11;

  // pwm alignment codes
  localparam logic [1:0] ALIGN_EDGE = 2'b00;
  localparam logic [1:0] ALIGN_UP = 2'b01;
  localparam logic [1:0] ALIGN_DOWN = 2'b10;
  localparam logic [1:0] ALIGN_BOTH = 2'b11;

  // single pulse sequencer
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ACTIVE = 2'b01,
    SP_DONE = 2'b10
  } tmb_pulse_t;

  // high byte of a 10-bit value, upper bits read as zero
  function automatic logic [7:0] tmb_high_byte(input logic [9:0] v);
    tmb_high_byte = {6'h00, v[9:8]};
  endfunction : tmb_high_byte

endpackage : tmb_pkg

// >>> rtl/tmb_chan_b_out.sv
/*
  channel B output and capture engine: compare, pwm, single pulse and
  edge capture on the three shared channel B pins.
  assumes: pin inputs synchronous to clk; counter and controls come
  from the register file in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tmb_chan_b_out
  import tmb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode_sel,
  input wire logic [1:0] pin_function,
  input wire logic output_level,
  input wire logic [1:0] pwm_align,
  input wire logic timer_on,
  input wire logic timer_on_rise,
  input wire logic [9:0] counter,
  input wire logic count_down,
  input wire logic [9:0] compare_b,
  input wire logic [2:0] pin_in,
  output logic pin_level,
  output logic capture_pulse
);

  // all state of the engine
  typedef struct packed {
    logic lvl;
    logic [2:0] pin_prev;
    tmb_pulse_t sp;
    logic cap;
  } tmb_out_state_t;

  tmb_out_state_t s_reg;
  tmb_out_state_t s_next;
  logic match; // raw comparator B match while running
  logic qmatch; // match qualified by pwm alignment
  logic any_rise; // rising edge on any pin
  logic any_fall; // falling edge on any pin

  // comparator and edge detectors
  always_comb begin
    match = timer_on && (counter == compare_b);
    any_rise = |(pin_in & ~s_reg.pin_prev);
    any_fall = |(~pin_in & s_reg.pin_prev);
    case (pwm_align)
      ALIGN_UP: qmatch = match && !count_down;
      ALIGN_DOWN: qmatch = match && count_down;
      default: qmatch = match;
    endcase
  end

  // next-state logic per mode
  always_comb begin
    s_next = s_reg;
    s_next.pin_prev = pin_in;
    s_next.cap = 1'b0;
    case (tmb_mode_t'(mode_sel))
      MODE_COMPARE: begin
        if (timer_on_rise) begin
          s_next.lvl = output_level;
        end else if (match) begin
          case (pin_function)
            CMP_FN_LOW: begin
              if (output_level != 1'b0) begin
                s_next.lvl = 1'b0;
              end
            end
            CMP_FN_HIGH: begin
              if (output_level != 1'b1) begin
                s_next.lvl = 1'b1;
              end
            end
            CMP_FN_TOGGLE: s_next.lvl = ~s_reg.lvl;
            default: s_next.lvl = s_reg.lvl;
          endcase
        end
      end
      MODE_PWM: begin
        // active level is output_level, inactive its inverse
        case (pin_function)
          PWM_FN_INACTIVE: s_next.lvl = ~output_level;
          PWM_FN_ACTIVE: s_next.lvl = output_level;
          PWM_FN_WAVE: begin
            if (!timer_on) begin
              s_next.lvl = ~output_level;
            end else if (pwm_align == ALIGN_EDGE) begin
              if (match) begin
                s_next.lvl = ~output_level;
              end else if (counter == CNT_ZERO) begin
                s_next.lvl = output_level;
              end
            end else if (qmatch) begin
              s_next.lvl = count_down ? output_level : ~output_level;
            end else if (pwm_align == ALIGN_UP && counter == CNT_ZERO) begin
              s_next.lvl = output_level;
            end else if (pwm_align == ALIGN_DOWN && counter == CNT_TOP) begin
              s_next.lvl = ~output_level;
            end
          end
          default: begin
            // single pulse: active from start until comparator B match
            case (s_reg.sp)
              SP_IDLE: if (timer_on_rise) s_next.sp = SP_ACTIVE;
              SP_ACTIVE: if (match) s_next.sp = SP_DONE;
              SP_DONE: if (timer_on_rise) s_next.sp = SP_ACTIVE;
              default: s_next.sp = SP_IDLE;
            endcase
            s_next.lvl = (s_next.sp == SP_ACTIVE) ? output_level
                                                   : ~output_level;
          end
        endcase
      end
      MODE_CAPTURE: begin
        case (pin_function)
          CAP_FN_RISE: s_next.cap = timer_on && any_rise;
          CAP_FN_FALL: s_next.cap = timer_on && any_fall;
          CAP_FN_BOTH: s_next.cap = timer_on && (any_rise || any_fall);
          default: s_next.cap = 1'b0;
        endcase
      end
      default: s_next.lvl = s_reg.lvl; // timer mode: pin unused
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{lvl: 1'b0, pin_prev: 3'h0, sp: SP_IDLE, cap: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin_level = s_reg.lvl;
  assign capture_pulse = s_reg.cap;

endmodule : tmb_chan_b_out
`default_nettype wire

// >>> rtl/tmb_timer_regs.sv
/*
  register file, 10-bit counter and channel B pin drive of the timer.
  assumes: a byte register port with one-cycle strobes and read data in
  the following cycle; three shared channel B pins with separate in,
  out and output enable; pin inputs synchronous to MCLK.
*/
`timescale 1ns/1ps
`default_nettype none
module tmb_timer_regs
  import tmb_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic CHAN_B_PIN_ZERO_IN,
  input wire logic CHAN_B_PIN_ONE_IN,
  input wire logic CHAN_B_PIN_TWO_IN,
  output logic CHAN_B_PIN_ZERO_OUT,
  output logic CHAN_B_PIN_ONE_OUT,
  output logic CHAN_B_PIN_TWO_OUT,
  output logic CHAN_B_PIN_ZERO_OE,
  output logic CHAN_B_PIN_ONE_OE,
  output logic CHAN_B_PIN_TWO_OE
);

  // all block state but the two reset synchroniser flops in one record
  typedef struct packed {
    logic [7:0] chan_b_control; // mode, function, level, polarity, align
    logic [9:0] compare_value_a; // comparator A value
    logic [9:0] compare_value_b; // comparator B value
    logic [9:0] counter; // running counter
    logic count_down; // counter direction in centre pwm
    logic timer_on_off; // counter run bit
    logic on_prev; // run bit one cycle ago
    logic pin_drive_en; // software pin drive enable
    logic capture_flag; // sticky capture event
    logic [7:0] rdata; // read data, one cycle after read strobe
    logic [2:0] pin_out; // registered pin levels
    logic [2:0] pin_oe; // registered pin enables
  } tmb_regs_state_t;

  tmb_regs_state_t s_reg;
  tmb_regs_state_t s_next;

  logic rst_meta_reg; // reset release, first stage
  logic rst_sync_reg; // reset release, second stage, used everywhere
  logic timer_on_rise; // run bit went low to high
  logic centre_pwm; // counter runs up and down
  logic pin_level; // channel B level from the engine
  logic capture_pulse; // capture event from the engine
  logic wr_ctrl; // write to timer_ctrl
  tmb_mode_t mode; // decoded channel B mode

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // decoded controls
  always_comb begin
    mode = tmb_mode_t'(s_reg.chan_b_control[POS_MODE_SEL +: 2]);
    timer_on_rise = s_reg.timer_on_off && !s_reg.on_prev;
    centre_pwm = (mode == MODE_PWM) &&
                 (s_reg.chan_b_control[POS_PWM_ALIGN +: 2] != ALIGN_EDGE);
    wr_ctrl = REG_WR && (REG_ADDR == OFS_TIMER_CTRL);
  end

  // output, pwm and capture engine for channel B
  tmb_chan_b_out u_chan_b_out (
    .clk(MCLK),
    .rst_n(rst_sync_reg),
    .mode_sel(s_reg.chan_b_control[POS_MODE_SEL +: 2]),
    .pin_function(s_reg.chan_b_control[POS_PIN_FUNCTION +: 2]),
    .output_level(s_reg.chan_b_control[POS_OUTPUT_LEVEL]),
    .pwm_align(s_reg.chan_b_control[POS_PWM_ALIGN +: 2]),
    .timer_on(s_reg.timer_on_off),
    .timer_on_rise(timer_on_rise),
    .counter(s_reg.counter),
    .count_down(s_reg.count_down),
    .compare_b(s_reg.compare_value_b),
    .pin_in({CHAN_B_PIN_TWO_IN, CHAN_B_PIN_ONE_IN, CHAN_B_PIN_ZERO_IN}),
    .pin_level(pin_level),
    .capture_pulse(capture_pulse)
  );

  // next state: register writes, counter, capture, reads and pins
  always_comb begin
    s_next = s_reg;
    s_next.on_prev = s_reg.timer_on_off;

    // register writes
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_CHAN_B_CONTROL: begin
          s_next.chan_b_control = REG_WDATA;
        end
        OFS_COMPARE_A_LOW: begin
          s_next.compare_value_a[7:0] = REG_WDATA;
        end
        OFS_COMPARE_A_HIGH: begin
          s_next.compare_value_a[9:8] = REG_WDATA[1:0];
        end
        OFS_COMPARE_B_LOW: begin
          s_next.compare_value_b[7:0] = REG_WDATA;
        end
        OFS_COMPARE_B_HIGH: begin
          s_next.compare_value_b[9:8] = REG_WDATA[1:0];
        end
        OFS_TIMER_CTRL: begin
          s_next.timer_on_off = REG_WDATA[POS_TIMER_ON];
          s_next.pin_drive_en = REG_WDATA[POS_PIN_DRIVE_EN];
        end
        default: begin
          // counter bytes and unmapped offsets ignore writes
        end
      endcase
    end

    // capture flag: write one clears, a new capture wins the same cycle
    if (wr_ctrl && REG_WDATA[POS_CAPTURE_FLAG]) begin
      s_next.capture_flag = 1'b0;
    end
    if (capture_pulse) begin
      s_next.capture_flag = 1'b1;
      s_next.compare_value_b = s_reg.counter;
    end

    // counter: zero on start, hold while stopped
    if (timer_on_rise) begin
      s_next.counter = CNT_ZERO;
      s_next.count_down = 1'b0;
    end else if (s_reg.timer_on_off) begin
      if (!centre_pwm) begin
        // edge aligned and non-pwm modes wrap upward
        s_next.counter = s_reg.counter + CNT_ONE;
        s_next.count_down = 1'b0;
      end else if (s_reg.count_down) begin
        // centre aligned, falling half
        if (s_reg.counter == CNT_ZERO) begin
          s_next.counter = CNT_ONE;
          s_next.count_down = 1'b0;
        end else begin
          s_next.counter = s_reg.counter - CNT_ONE;
        end
      end else begin
        // centre aligned, rising half
        if (s_reg.counter == CNT_TOP) begin
          s_next.counter = s_reg.counter - CNT_ONE;
          s_next.count_down = 1'b1;
        end else begin
          s_next.counter = s_reg.counter + CNT_ONE;
        end
      end
    end else begin
      s_next.counter = s_reg.counter;
    end

    // read data stands only in the cycle after the strobe
    s_next.rdata = RST_READ_DATA;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_CHAN_B_CONTROL: s_next.rdata = s_reg.chan_b_control;
        OFS_COUNTER_LOW: s_next.rdata = s_reg.counter[7:0];
        OFS_COUNTER_HIGH: begin
          s_next.rdata = tmb_high_byte(s_reg.counter);
        end
        OFS_COMPARE_A_LOW: s_next.rdata = s_reg.compare_value_a[7:0];
        OFS_COMPARE_A_HIGH: begin
          s_next.rdata = tmb_high_byte(s_reg.compare_value_a);
        end
        OFS_COMPARE_B_LOW: s_next.rdata = s_reg.compare_value_b[7:0];
        OFS_COMPARE_B_HIGH: begin
          s_next.rdata = tmb_high_byte(s_reg.compare_value_b);
        end
        OFS_TIMER_CTRL: begin
          s_next.rdata[POS_TIMER_ON] = s_reg.timer_on_off;
          s_next.rdata[POS_PIN_DRIVE_EN] = s_reg.pin_drive_en;
          s_next.rdata[POS_CAPTURE_FLAG] = s_reg.capture_flag;
          s_next.rdata[POS_OUT_STATE] = pin_level;
          s_next.rdata[POS_COUNT_DOWN] = s_reg.count_down;
        end
        default: s_next.rdata = RST_READ_DATA; // unmapped reads zero
      endcase
    end

    // pin levels: polarity applies except in timer mode
    if (mode == MODE_TIMER) begin
      s_next.pin_out = {3{pin_level}};
    end else begin
      s_next.pin_out = {3{pin_level ^
                          s_reg.chan_b_control[POS_POLARITY]}};
    end

    // pin drive only in output modes and when software enables it
    if (s_reg.pin_drive_en &&
        (mode == MODE_COMPARE || mode == MODE_PWM)) begin
      s_next.pin_oe = 3'h7;
    end else begin
      s_next.pin_oe = 3'h0;
    end
  end

  // state register, cleared by the synchronised reset
  always_ff @(posedge MCLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg <= '{
        chan_b_control: RST_CHAN_B_CONTROL,
        compare_value_a: RST_COMPARE,
        compare_value_b: RST_COMPARE,
        counter: RST_COUNTER,
        count_down: 1'b0,
        timer_on_off: 1'b0,
        on_prev: 1'b0,
        pin_drive_en: 1'b0,
        capture_flag: 1'b0,
        rdata: RST_READ_DATA,
        pin_out: 3'h0,
        pin_oe: 3'h0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // every output straight from the state register
  assign REG_RDATA = s_reg.rdata;
  assign CHAN_B_PIN_ZERO_OUT = s_reg.pin_out[0];
  assign CHAN_B_PIN_ONE_OUT = s_reg.pin_out[1];
  assign CHAN_B_PIN_TWO_OUT = s_reg.pin_out[2];
  assign CHAN_B_PIN_ZERO_OE = s_reg.pin_oe[0];
  assign CHAN_B_PIN_ONE_OE = s_reg.pin_oe[1];
  assign CHAN_B_PIN_TWO_OE = s_reg.pin_oe[2];

endmodule : tmb_timer_regs
`default_nettype wire

// >>> verification/tmb_regs_properties.sv
/* port checker for the channel B timer register block.
   assumes: bound to tmb_timer_regs; one clock, MCLK. */
`timescale 1ns/1ps
`default_nettype none
module tmb_regs_properties
  import tmb_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic CHAN_B_PIN_ZERO_OUT,
  input wire logic CHAN_B_PIN_ONE_OUT,
  input wire logic CHAN_B_PIN_TWO_OUT,
  input wire logic CHAN_B_PIN_ZERO_OE,
  input wire logic CHAN_B_PIN_ONE_OE,
  input wire logic CHAN_B_PIN_TWO_OE
);
  logic [1:0] mode_reg; // shadow of the written mode field
  logic drive_reg; // shadow of the pin drive enable
  logic [1:0] since_reg; // cycles since either shadow was written
  // follow software writes so drive rules can be judged once settled
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= 2'b00;
      drive_reg <= 1'b0;
      since_reg <= 2'd3;
    end else if (REG_WR && REG_ADDR == OFS_CHAN_B_CONTROL) begin
      mode_reg <= REG_WDATA[7:6];
      since_reg <= 2'd0;
    end else if (REG_WR && REG_ADDR == OFS_TIMER_CTRL) begin
      drive_reg <= REG_WDATA[POS_PIN_DRIVE_EN];
      since_reg <= 2'd0;
    end else if (since_reg != 2'd3) begin
      since_reg <= since_reg + 2'd1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_rdata_idle: assert property (
    (REG_RDATA != 8'h00) |-> $past(REG_RD)) else $error("stray read data");
  chk_cnt_high: assert property (
    REG_RD && REG_ADDR == OFS_COUNTER_HIGH |=> REG_RDATA[7:2] == 6'h00)
    else $error("counter high upper bits set");
  chk_cmpa_high: assert property (
    REG_RD && REG_ADDR == OFS_COMPARE_A_HIGH |=> REG_RDATA[7:2] == 6'h00)
    else $error("compare a high upper bits set");
  chk_cmpb_high: assert property (
    REG_RD && REG_ADDR == OFS_COMPARE_B_HIGH |=> REG_RDATA[7:2] == 6'h00)
    else $error("compare b high upper bits set");
  chk_pins_equal: assert property (
    CHAN_B_PIN_ONE_OUT == CHAN_B_PIN_ZERO_OUT &&
    CHAN_B_PIN_TWO_OUT == CHAN_B_PIN_ZERO_OUT) else $error("pin levels differ");
  chk_oe_equal: assert property (
    CHAN_B_PIN_ONE_OE == CHAN_B_PIN_ZERO_OE &&
    CHAN_B_PIN_TWO_OE == CHAN_B_PIN_ZERO_OE) else $error("pin enables differ");
  chk_release_zero: assert property (
    $rose(RST_N) |-> REG_RDATA == 8'h00 && !CHAN_B_PIN_ZERO_OE)
    else $error("outputs not zero at reset release");
  chk_oe_off: assert property (
    since_reg == 2'd3 && (mode_reg == MODE_TIMER ||
    mode_reg == MODE_CAPTURE || !drive_reg) |-> !CHAN_B_PIN_ZERO_OE)
    else $error("pin driven when it must be released");
  cov_ctl_write: cover property (REG_WR && REG_ADDR == OFS_CHAN_B_CONTROL);
  cov_pin_high: cover property (CHAN_B_PIN_ZERO_OE && CHAN_B_PIN_ZERO_OUT);
  cov_cnt_read: cover property (REG_RD && REG_ADDR == OFS_COUNTER_HIGH);
endmodule : tmb_regs_properties
bind tmb_timer_regs tmb_regs_properties u_props (.MCLK(MCLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CHAN_B_PIN_ZERO_OUT(CHAN_B_PIN_ZERO_OUT),
  .CHAN_B_PIN_ONE_OUT(CHAN_B_PIN_ONE_OUT),
  .CHAN_B_PIN_TWO_OUT(CHAN_B_PIN_TWO_OUT),
  .CHAN_B_PIN_ZERO_OE(CHAN_B_PIN_ZERO_OE),
  .CHAN_B_PIN_ONE_OE(CHAN_B_PIN_ONE_OE),
  .CHAN_B_PIN_TWO_OE(CHAN_B_PIN_TWO_OE));
`default_nettype wire

// >>> verification/tmb_cpu_model.sv
/* cpu model: software that programs the timer over the byte port.
   assumes: strobes sampled at rising clk, read data one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module tmb_cpu_model
  import tmb_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // bus idle at time zero
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write; data inverted once released
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : wr_reg
  // one-cycle read; data taken once the answer has landed
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // reprogram the channel only with the timer stopped
  task automatic cfg(input logic [7:0] ctl, input logic [7:0] tctl);
    wr_reg(OFS_TIMER_CTRL, 8'h00);
    wr_reg(OFS_CHAN_B_CONTROL, ctl);
    if (ctl[7:6] == MODE_TIMER) tctl[POS_PIN_DRIVE_EN] = 1'b0;
    wr_reg(OFS_TIMER_CTRL, tctl);
  endtask : cfg
endmodule : tmb_cpu_model
`default_nettype wire

// >>> verification/tb_top.sv
/* testbench for the channel B timer register block.
   assumes: cpu model drives the byte port; bench drives pin inputs. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmb_pkg::*;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic [2:0] pin_in = 3'b000;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  int err_total = 0;
  int compares = 0;
  logic [7:0] d;
  always #4 MCLK = ~MCLK;
  tmb_cpu_model cpu (.clk(MCLK), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  tmb_timer_regs DUT (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CHAN_B_PIN_ZERO_IN(pin_in[0]), .CHAN_B_PIN_ONE_IN(pin_in[1]),
    .CHAN_B_PIN_TWO_IN(pin_in[2]), .CHAN_B_PIN_ZERO_OUT(pin_out[0]),
    .CHAN_B_PIN_ONE_OUT(pin_out[1]), .CHAN_B_PIN_TWO_OUT(pin_out[2]),
    .CHAN_B_PIN_ZERO_OE(pin_oe[0]), .CHAN_B_PIN_ONE_OE(pin_oe[1]),
    .CHAN_B_PIN_TWO_OE(pin_oe[2]));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string n, input logic [7:0] lo,
                         input logic [7:0] hi, input logic [7:0] g);
    compares++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      err_total++;
      $display("wrong value %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask : chk_rng
  // write then read back one register
  task automatic wrrd(input logic [3:0] a, input logic [7:0] v,
                      input logic [7:0] e);
    logic [7:0] g;
    cpu.wr_reg(a, v);
    cpu.rd_reg(a, g);
    chk("readback", e, g);
  endtask : wrrd
  // every place reads zero after reset, unmapped ones too
  task automatic t_reset();
    for (int a = 0; a < 16; a++) begin
      cpu.rd_reg(a[3:0], d);
      chk("reset value", 8'h00, d);
    end
  endtask : t_reset
  // access kinds of the register table
  task automatic t_regs();
    for (int a = 0; a < 4; a++) begin
      wrrd(OFS_CHAN_B_CONTROL, 8'hA4 | a[7:0], 8'hA4 | a[7:0]);
    end
    wrrd(OFS_COMPARE_A_LOW, 8'h5A, 8'h5A);
    wrrd(OFS_COMPARE_A_HIGH, 8'hFF, 8'h03);
    wrrd(OFS_COMPARE_B_LOW, 8'hC3, 8'hC3);
    wrrd(OFS_COMPARE_B_HIGH, 8'hFE, 8'h02);
    wrrd(OFS_COUNTER_LOW, 8'h77, 8'h00);
    wrrd(OFS_COUNTER_HIGH, 8'hFF, 8'h00);
    wrrd(4'h9, 8'hFF, 8'h00);
    cpu.wr_reg(OFS_CHAN_B_CONTROL, 8'h00);
  endtask : t_regs
  // count to 298..300, hold after stop, clear on restart
  task automatic t_counter();
    cpu.wr_reg(OFS_TIMER_CTRL, 8'h01);
    repeat (298) @(posedge MCLK);
    cpu.wr_reg(OFS_TIMER_CTRL, 8'h00);
    cpu.rd_reg(OFS_COUNTER_LOW, d);
    chk_rng("counter low", 8'h2A, 8'h2C, d);
    cpu.rd_reg(OFS_COUNTER_HIGH, d);
    chk("counter high", 8'h01, d);
    repeat (20) @(posedge MCLK);
    cpu.rd_reg(OFS_COUNTER_LOW, d);
    chk_rng("counter held", 8'h2A, 8'h2C, d);
    cpu.wr_reg(OFS_TIMER_CTRL, 8'h01);
    repeat (3) @(posedge MCLK);
    cpu.rd_reg(OFS_COUNTER_LOW, d);
    chk_rng("counter restart", 8'h00, 8'h08, d);
    cpu.wr_reg(OFS_TIMER_CTRL, 8'h00);
  endtask : t_counter
  // start the timer, look at the pins before and after the match at 20
  task automatic t_out(input logic [1:0] m, input logic [1:0] fn,
                       input logic lv, input logic pl, input logic e0,
                       input logic e1, input logic oe, input logic [1:0] al);
    cpu.cfg({m, fn, lv, pl, al}, 8'h03);
    repeat (10) @(posedge MCLK);
    #1 chk("pin enable", {5'h00, {3{oe}}}, {5'h00, pin_oe});
    if (oe) chk("pin early", {5'h00, {3{e0}}}, {5'h00, pin_out});
    repeat (30) @(posedge MCLK);
    #1 if (oe) chk("pin late", {5'h00, {3{e1}}}, {5'h00, pin_out});
  endtask : t_out
  // every function code of compare and pwm, then timer mode
  task automatic t_modes();
    logic [3:0] late;
    logic lv;
    logic pl;
    cpu.wr_reg(OFS_COMPARE_B_LOW, 8'h14);
    cpu.wr_reg(OFS_COMPARE_B_HIGH, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lv = i[2];
      pl = i[0] ^ i[1];
      late = {~lv, 1'b1, 1'b0, lv};
      t_out(MODE_COMPARE, i[1:0], lv, pl, lv ^ pl, late[i[1:0]] ^ pl, 1'b1,
            ALIGN_EDGE);
    end
    for (int i = 0; i < 4; i++) begin
      lv = ~i[0];
      pl = i[1];
      t_out(MODE_PWM, i[1:0], lv, pl, (i == 0) ^ lv ^ pl,
            (i != 1) ^ lv ^ pl, 1'b1, ALIGN_EDGE);
    end
    // centre up: active from zero, inactive at the rising match
    t_out(MODE_PWM, PWM_FN_WAVE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ALIGN_UP);
    // centre down: stays inactive until the falling match
    t_out(MODE_PWM, PWM_FN_WAVE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
          ALIGN_DOWN);
    t_out(MODE_TIMER, 2'b10, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
          ALIGN_EDGE);
  endtask : t_modes
  // rising then falling edge on one pin per capture function code
  task automatic t_cap();
    for (int i = 0; i < 4; i++) begin
      cpu.cfg({MODE_CAPTURE, i[1:0], 4'h0}, 8'h01);
      @(posedge MCLK);
      pin_in <= 3'b001 << (i % 3);
      repeat (4) @(posedge MCLK);
      cpu.rd_reg(OFS_TIMER_CTRL, d);
      chk("capture on rise", {5'h00, i == 0 || i == 2, 2'b00}, d & 8'h04);
      cpu.wr_reg(OFS_TIMER_CTRL, 8'h05);
      pin_in <= 3'b000;
      repeat (4) @(posedge MCLK);
      cpu.rd_reg(OFS_TIMER_CTRL, d);
      chk("capture on fall", {5'h00, i == 1 || i == 2, 2'b00}, d & 8'h04);
      cpu.wr_reg(OFS_TIMER_CTRL, 8'h05);
      #1 chk("capture oe", 8'h00, {5'h00, pin_oe});
    end
  endtask : t_cap
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // watchdog: the run needs about 1200 cycles
  initial begin
    #100_000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_reset();
    t_regs();
    t_counter();
    t_modes();
    t_cap();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
